// File: inc/pscd_pkg.sv
package pscd_pkg;
	// Command field layout and codes.
	// Device type nibble; the same value is also the status opcode.
	localparam logic [3:0] TYPE_ID_VAL    = 4'h6;
	localparam logic [3:0] OP_READ_WIPER  = 4'h9;
	localparam logic [3:0] OP_WRITE_WIPER = 4'hA;
	localparam logic [3:0] OP_READ_STORE  = 4'hB;
	localparam logic [3:0] OP_WRITE_STORE = 4'hC;
	localparam logic [3:0] OP_STORE_TO_WP = 4'hD;
	localparam logic [3:0] OP_WP_TO_STORE = 4'hE;
	localparam logic [3:0] OP_STEP        = 4'h2;
	localparam logic [3:0] OP_STATUS      = TYPE_ID_VAL;
	localparam int         DEV_ADDR_LSB   = 0;
	localparam int         OPCODE_LSB     = 4;
	localparam int         REG_SEL_LSB    = 2;
	localparam int         BANK_SEL_LSB   = 0;
	localparam int         BYTE_BITS      = 8;
	localparam int         STORE_DEPTH    = 16;
	// Reset values and tap limits.
	localparam logic [7:0] WIPER_RST      = 8'h00;
	localparam logic [7:0] STORE_RST      = 8'h00;
	localparam logic [7:0] TAP_MAX        = 8'hFF;
	localparam logic [7:0] TAP_MIN        = 8'h00;
	// Nonvolatile write time.
	localparam int         NV_WRITE_US    = 10;
	localparam int         CLK_MHZ        = 125;
	localparam int         NV_WRITE_CYC   = NV_WRITE_US * CLK_MHZ;
	localparam int         NV_CNT_W       = 11;
endpackage

// File: rtl/pscd_nv_timer.sv
`timescale 1ns/1ns
module pscd_nv_timer
	import pscd_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	// Control
	input  wire logic start_i,
	output logic      busy_o
);
	logic [NV_CNT_W-1:0] cnt_ff;
	logic [NV_CNT_W-1:0] nxt_cnt;
	logic                busy_ff;
	logic                nxt_busy;
	localparam logic [NV_CNT_W-1:0] LAST = NV_CNT_W'(NV_WRITE_CYC - 1);

	assign nxt_busy = start_i ? 1'b1 : (busy_ff && cnt_ff != LAST);
	assign nxt_cnt  = (start_i || !busy_ff) ? '0 : cnt_ff + 1'b1;
	assign busy_o   = busy_ff;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			busy_ff <= 1'b0;
			cnt_ff  <= '0;
		end else begin
			busy_ff <= nxt_busy;
			cnt_ff  <= nxt_cnt;
		end
	end
endmodule // pscd_nv_timer

// File: rtl/pscd_decoder.sv
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: Host opens with select fall, type, address.
// RQ2: Write-wiper loads received byte into wiper.
// RQ3: Read-stored shifts selected byte out until deselect.
// RQ4: All data bytes move MSB first.
// RQ5: Write-stored starts nonvolatile write on deselect.
// RQ6: Wiper-to-stored copies wiper, writes on deselect.
// RQ7: Stored-to-wiper copies selected byte into wiper.
// RQ8: Step command then unlimited step clocks.
// RQ9: Clock high with input high steps up.
// RQ10: Clock high with input low steps down.
// RQ11: Status returns seven zeros and write flag.
// RQ12: Don't-care bits never change addressing.
// RQ13: Wiper register drives tap; read returns it.
// RQ14: Write flag set during save, then clears.
// RQ15: Only bank zero allows wiper operations.
// RQ16: Stepping saturates at both ends.
module pscd_decoder
	import pscd_pkg::*;
#(
	parameter logic [1:0] DEV_ADDR = 2'h0
) (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       sys_rst_i,
	// Serial pins
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       si_i,
	output logic            so_o,
	output logic            so_oe_o,
	// Potentiometer tap and status
	output logic [7:0]      tap_o,
	output logic            write_in_progress_o
);
	typedef enum logic [2:0] {
		ST_HDR, ST_OP, ST_WDATA, ST_RDATA, ST_STEP, ST_IGNORE
	} pscd_state_t;

	logic [2:0] sck_s_ff, cs_s_ff, si_s_ff;
	logic [7:0] shift_ff;
	logic [2:0] bit_ff;
	logic [3:0] op_ff;
	logic [3:0] sel_ff;
	logic [7:0] wiper_position_reg_ff;
	logic [7:0] stored_position_reg_ff [STORE_DEPTH];
	logic [7:0] tx_ff;
	logic       so_ff, so_oe_ff, nv_pend_ff;
	logic [3:0] nv_idx_ff;
	logic [7:0] nv_data_ff;
	pscd_state_t state_ff;

	always_ff @(posedge clk_sys_i) begin
		sck_s_ff <= {sck_s_ff[1:0], sck_i};
		cs_s_ff  <= {cs_s_ff[1:0], cs_n_i};
		si_s_ff  <= {si_s_ff[1:0], si_i};
	end

	wire       sck_rise  = sck_s_ff[1] & ~sck_s_ff[2];
	wire       sck_fall  = ~sck_s_ff[1] & sck_s_ff[2];
	wire       cs_fall   = ~cs_s_ff[1] & cs_s_ff[2];
	wire       cs_rise   = cs_s_ff[1] & ~cs_s_ff[2];
	wire       active    = ~cs_s_ff[1];
	wire       si_s      = si_s_ff[1];
	// RQ4: MSB first shift.
	wire [7:0] shift_in  = {shift_ff[6:0], si_s};
	wire       byte_done = sck_rise && bit_ff == 3'd7;
	// RQ1: type and address check.
	wire       hdr_ok    = shift_in[7:4] == TYPE_ID_VAL &&
		shift_in[3:2] == 2'b00 && shift_in[1:0] == DEV_ADDR;
	wire [3:0] sel_in    = shift_in[3:0];
	wire       bank0     = sel_in[1:0] == 2'b00;
	// RQ12: masked select; step ignores upper bits.
	wire [3:0] reg_idx   = {sel_in[1:0], sel_in[3:2]};
	wire [3:0] b0_idx    = {2'b00, sel_in[3:2]};
	wire [3:0] st_idx    = {sel_ff[1:0], sel_ff[3:2]};
	wire       at_max    = wiper_position_reg_ff == TAP_MAX;
	wire       at_min    = wiper_position_reg_ff == TAP_MIN;
	wire       nv_busy;

	pscd_nv_timer u_timer (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (nv_pend_ff && cs_rise),
		.busy_o    (nv_busy)
	);

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state_ff <= ST_IGNORE;
			shift_ff <= 8'h00;
			bit_ff <= 3'd0;
			op_ff <= 4'h0;
			sel_ff <= 4'h0;
			wiper_position_reg_ff <= WIPER_RST;
			tx_ff <= 8'h00;
			so_ff <= 1'b0;
			so_oe_ff <= 1'b0;
			nv_pend_ff <= 1'b0;
			nv_idx_ff <= 4'h0;
			nv_data_ff <= 8'h00;
		end else if (cs_fall) begin
			state_ff <= ST_HDR;
			bit_ff <= 3'd0;
			nv_pend_ff <= 1'b0;
		end else if (!active) begin
			state_ff <= ST_IGNORE;
			so_oe_ff <= 1'b0;
			nv_pend_ff <= 1'b0;
		end else begin
			if (sck_rise) begin
				shift_ff <= shift_in;
				bit_ff <= bit_ff + 3'd1;
			end
			if (sck_fall && state_ff == ST_RDATA) begin
				so_ff <= tx_ff[7];
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
			case (state_ff)
			ST_HDR: begin
				if (byte_done)
					state_ff <= hdr_ok ? ST_OP : ST_IGNORE;
			end
			ST_OP: begin
				if (byte_done) begin
					op_ff <= shift_in[7:4];
					sel_ff <= sel_in;
					state_ff <= ST_IGNORE;
					case (shift_in[7:4])
					OP_READ_WIPER: begin
						// RQ13: read returns wiper.
						tx_ff <= wiper_position_reg_ff;
						state_ff <= bank0 ? ST_RDATA : ST_IGNORE;
					end
					OP_READ_STORE: begin
						// RQ3: load selected stored byte.
						tx_ff <= stored_position_reg_ff[reg_idx];
						state_ff <= ST_RDATA;
					end
					OP_STATUS: begin
						// RQ11: status byte.
						tx_ff <= {7'h00, nv_busy};
						state_ff <= ST_RDATA;
					end
					// RQ15: wiper write bank zero.
					OP_WRITE_WIPER:
						state_ff <= bank0 ? ST_WDATA : ST_IGNORE;
					OP_WRITE_STORE:
						state_ff <= ST_WDATA;
					OP_STORE_TO_WP: begin
						// RQ7: stored to wiper, RQ15 bank zero.
						if (bank0 && !nv_busy)
							wiper_position_reg_ff <=
								stored_position_reg_ff[b0_idx];
					end
					OP_WP_TO_STORE: begin
						// RQ6: wiper to stored, written on deselect.
						if (bank0 && !nv_busy) begin
							nv_pend_ff <= 1'b1;
							nv_idx_ff <= b0_idx;
							nv_data_ff <= wiper_position_reg_ff;
						end
					end
					OP_STEP: begin
						// RQ8: enter step phase.
						if (bank0)
							state_ff <= ST_STEP;
					end
					default: state_ff <= ST_IGNORE;
					endcase
				end
			end
			ST_WDATA: begin
				if (byte_done) begin
					state_ff <= ST_IGNORE;
					if (op_ff == OP_WRITE_WIPER) begin
						// RQ2: load wiper.
						wiper_position_reg_ff <= shift_in;
					end else if (!nv_busy) begin
						// RQ5: arm nonvolatile write.
						nv_pend_ff <= 1'b1;
						nv_idx_ff <= st_idx;
						nv_data_ff <= shift_in;
					end
				end
			end
			ST_RDATA: so_oe_ff <= 1'b1;
			ST_STEP: begin
				if (sck_rise) begin
					// RQ9: up, RQ16 saturate.
					if (si_s && !at_max)
						wiper_position_reg_ff <=
							wiper_position_reg_ff + 8'h01;
					// RQ10: down, RQ16 saturate.
					else if (!si_s && !at_min)
						wiper_position_reg_ff <=
							wiper_position_reg_ff - 8'h01;
				end
			end
			default: state_ff <= ST_IGNORE;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < STORE_DEPTH; g = g + 1) begin : g_store
			always_ff @(posedge clk_sys_i) begin
				if (sys_rst_i)
					stored_position_reg_ff[g] <= STORE_RST;
				// RQ14: save on deselect.
				else if (nv_pend_ff && cs_rise && nv_idx_ff == g)
					stored_position_reg_ff[g] <= nv_data_ff;
			end
		end
	endgenerate

	logic [7:0] tap_ff;
	logic       wip_ff;
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			tap_ff <= WIPER_RST;
			wip_ff <= 1'b0;
		end else begin
			tap_ff <= wiper_position_reg_ff;
			// RQ14: flag follows save timer.
			wip_ff <= nv_busy;
		end
	end

	assign tap_o = tap_ff;
	assign write_in_progress_o = wip_ff;
	assign so_o = so_ff;
	assign so_oe_o = so_oe_ff;
endmodule // pscd_decoder

// File: bench/pscd_decoder_props.sv
`timescale 1ns/1ns
module pscd_decoder_props
	import pscd_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       sys_rst_i,
	// Pins and outputs
	input wire logic       sck_i,
	input wire logic       cs_n_i,
	input wire logic       si_i,
	input wire logic       so_o,
	input wire logic       so_oe_o,
	input wire logic [7:0] tap_o,
	input wire logic       write_in_progress_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	logic [NV_CNT_W-1:0] cnt_ff;
	logic [NV_CNT_W-1:0] nxt_cnt;
	assign nxt_cnt = write_in_progress_o ? cnt_ff + 1'b1 : '0;
	always_ff @(posedge clk_sys_i)
		cnt_ff <= sys_rst_i ? '0 : nxt_cnt;
	a_oe_idle_off: assert property (
		cs_n_i [*6] |-> !so_oe_o) else $error("so driven idle");
	a_oe_rise_sel: assert property (
		$rose(so_oe_o) |-> !cs_n_i) else $error("so enabled idle");
	a_so_stands: assert property (
		so_oe_o && $changed(so_o) |-> !sck_i) else $error("so moved");
	a_tap_idle: assert property (
		cs_n_i [*8] |=> $stable(tap_o)) else $error("tap moved");
	a_save_on_idle: assert property (
		$rose(write_in_progress_o) |-> cs_n_i) else $error("save early");
	a_save_not_sel: assert property (
		!cs_n_i && !write_in_progress_o |=> !write_in_progress_o)
		else $error("save while selected");
	a_save_max_len: assert property (
		write_in_progress_o |-> cnt_ff <= NV_WRITE_CYC)
		else $error("save too long");
	a_save_min_len: assert property (
		$fell(write_in_progress_o) |-> cnt_ff >= NV_WRITE_CYC - 1)
		else $error("save too short");
endmodule // pscd_decoder_props

bind pscd_decoder pscd_decoder_props props_i (
	.clk_sys_i           (clk_sys_i),
	.sys_rst_i           (sys_rst_i),
	.sck_i               (sck_i),
	.cs_n_i              (cs_n_i),
	.si_i                (si_i),
	.so_o                (so_o),
	.so_oe_o             (so_oe_o),
	.tap_o               (tap_o),
	.write_in_progress_o (write_in_progress_o)
);

// File: bench/pscd_spi_host.sv
`timescale 1ns/1ns
module pscd_spi_host (
	// Clock
	input  wire logic clk_sys_i,
	// Serial pins
	input  wire logic so_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      si_o
);
	logic [7:0] rx;
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// select fall, MSB first, step clocks.
	task automatic xfer(input logic [23:0] d, input int n, input int hw);
		@(posedge clk_sys_i) cs_n_o <= 1'b0;
		repeat (hw) @(posedge clk_sys_i);
		for (int i = 23; i > 23 - n; i--) begin
			si_o <= d[i];
			repeat (hw) @(posedge clk_sys_i);
			sck_o <= 1'b1;
			rx <= {rx[6:0], so_i};
			repeat (hw) @(posedge clk_sys_i);
			sck_o <= 1'b0;
		end
		repeat (hw) @(posedge clk_sys_i);
		cs_n_o <= 1'b1;
		// A released line must not keep its last value.
		si_o <= ~si_o;
		repeat (hw) @(posedge clk_sys_i);
	endtask
endmodule // pscd_spi_host

// File: bench/pscd_decoder_bench.sv
`timescale 1ns/1ns
module pscd_decoder_bench import pscd_pkg::*;;
	logic       clk_sys_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       sck;
	logic       cs_n;
	logic       si;
	logic       so;
	logic       so_oe;
	logic       write_in_progress;
	logic [7:0] tap;
	logic [7:0] st;
	logic [7:0] pt;
	logic [3:0] idx;
	logic [31:0] rng = 32'h4DE2;
	int         miscompares = 0;
	int         comparisons = 0;
	int         wiper;
	int         store [16];
	always #4 clk_sys_i = ~clk_sys_i;
	// A released output shows the inverse, so stale data is caught.
	pscd_spi_host h (.clk_sys_i(clk_sys_i), .so_i(so_oe ? so : ~so),
		.sck_o(sck), .cs_n_o(cs_n), .si_o(si));
	pscd_decoder #(.DEV_ADDR(2'h2)) dut (.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
		.so_o(so), .so_oe_o(so_oe), .tap_o(tap),
		.write_in_progress_o(write_in_progress));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmd(input logic [3:0] op, input logic [3:0] sel,
		input logic [7:0] dat, input int n);
		h.xfer({TYPE_ID_VAL, 4'h2, op, sel, dat}, n, 10);
	endtask
	task automatic save_wait();
		for (int i = 0; i < 2000 && write_in_progress !== 1'b0; i++)
			@(posedge clk_sys_i);
	endtask
	initial begin
		repeat (20) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		for (int k = 0; k < 4; k++) begin
			rng = xs(rng);
			wiper = rng[7:0];
			cmd(OP_WRITE_WIPER, 4'h0, rng[7:0], 24);
			chk(tap, wiper[7:0]);
			cmd(OP_READ_WIPER, 4'h0, 8'h00, 24);
			chk(h.rx, wiper[7:0]);
			idx = {k[1:0], rng[9:8]};
			store[idx] = rng[23:16];
			cmd(OP_WRITE_STORE, idx, rng[23:16], 24);
			// A stored write while the save runs is refused.
			cmd(OP_WRITE_STORE, idx, ~rng[23:16], 24);
			cmd(OP_STATUS, 4'h1, 8'h00, 24);
			chk(h.rx, 8'h01);
			save_wait();
			cmd(OP_STATUS, 4'h1, 8'h00, 24);
			chk(h.rx, 8'h00);
			cmd(OP_READ_STORE, idx, 8'h00, 24);
			chk(h.rx, store[idx][7:0]);
			chk({7'h00, so_oe}, 8'h00);
		end
		cmd(OP_WP_TO_STORE, 4'h8, 8'h00, 16);
		store[8] = wiper;
		save_wait();
		cmd(OP_READ_STORE, 4'h8, 8'h00, 24);
		chk(h.rx, store[8][7:0]);
		cmd(OP_WRITE_WIPER, 4'h0, ~store[8][7:0], 24);
		cmd(OP_STORE_TO_WP, 4'h8, 8'h00, 16);
		chk(tap, store[8][7:0]);
		cmd(OP_STORE_TO_WP, 4'h9, 8'h00, 16);
		chk(tap, store[8][7:0]);
		cmd(OP_WRITE_WIPER, 4'h1, ~tap, 24);
		chk(tap, store[8][7:0]);
		h.xfer({TYPE_ID_VAL, 4'h1, OP_WRITE_WIPER, 4'h0, ~tap}, 24, 25);
		chk(tap, store[8][7:0]);
		for (int j = 0; j < 3; j++) begin
			rng = xs(rng);
			st = (j == 0) ? 8'hFC : (j == 1) ? 8'h03 : rng[7:0];
			pt = (j == 0) ? 8'hFF : (j == 1) ? 8'h00 : rng[15:8];
			cmd(OP_WRITE_WIPER, 4'h0, st, 24);
			wiper = st;
			for (int b = 7; b >= 0; b--)
				wiper = pt[b] ? (wiper < 255 ? wiper + 1 : 255)
					: (wiper > 0 ? wiper - 1 : 0);
			// Upper select bits set: they must not matter.
			cmd(OP_STEP, 4'hC, pt, 24);
			chk(tap, wiper[7:0]);
		end
		end_sim();
	end
	initial begin
		repeat (60000) @(posedge clk_sys_i);
		miscompares++;
		end_sim();
	end
endmodule // pscd_decoder_bench
